// >>> rtl/aocr_overrange_det.sv
// Over-range detector for one channel: magnitude compare and fixed delay.
// Assumes samples are two's complement and on the core clock.
`timescale 1ns/1ps
module aocr_overrange_det #(
	parameter int SAMPLE_W = 12,
	parameter int DELAY = aocr_pkg::AOCR_OVR_DELAY
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Sample and threshold
	input wire logic [SAMPLE_W-1:0] sample_i,
	input wire logic [aocr_pkg::AOCR_THR_W-1:0] thr_i,
	// Flag
	output logic overrange_flag_o
);
	import aocr_pkg::*;

	logic [SAMPLE_W-1:0] mag;
	logic [SAMPLE_W-1:0] level;
	logic hit;
	logic [DELAY-1:0] pipe_d, pipe_q;

	// ----------------------------------------------------------------
	// Compare and delay line
	// ----------------------------------------------------------------
	always_comb begin
		mag = sample_i[SAMPLE_W-1] ? SAMPLE_W'(-sample_i) : sample_i;
		// level is full scale times code over 16
		level = SAMPLE_W'({thr_i, {(SAMPLE_W-5){1'b0}}});
		hit = (mag >= level);
		pipe_d = {pipe_q[DELAY-2:0], hit};
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pipe_q <= '0;
		end else begin
			pipe_q <= pipe_d;
		end
	end

	assign overrange_flag_o = pipe_q[DELAY-1];

endmodule

// >>> rtl/aocr_pkg.sv
// Constants, register map and types for the converter's configuration bank.
// Assumes a single core clock domain; serial pins arrive asynchronously.
package aocr_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] AOCR_OFS_OVR_THR = 8'h02;
	localparam logic [7:0] AOCR_OFS_LOOP_A = 8'h03;
	localparam logic [7:0] AOCR_OFS_SYNC_WIDE = 8'h0E;
	localparam logic [7:0] AOCR_OFS_SYNC_REF = 8'h0F;
	localparam logic [7:0] AOCR_OFS_LOOP_B = 8'h1A;
	localparam logic [7:0] AOCR_OFS_SOFT_RST = 8'h2C;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int AOCR_THR_LSB = 7;
	localparam int AOCR_THR_W = 4;
	localparam int AOCR_THR_FIXED_BIT = 14;
	localparam int AOCR_LOOP_BIT = 14;
	localparam int AOCR_SYNCW_LSB = 2;
	localparam int AOCR_SYNCW_W = 14;
	localparam int AOCR_SYNCN_LSB = 12;
	localparam int AOCR_SYNCN_W = 4;
	localparam int AOCR_VREF_LSB = 4;
	localparam int AOCR_VREF_W = 3;

	// ----------------------------------------------------------------
	// Reset values and special codes
	// ----------------------------------------------------------------
	localparam logic [3:0] AOCR_THR_RST = 4'hF;
	localparam logic [15:0] AOCR_LOOP_RST = 16'h4B18;
	localparam logic [13:0] AOCR_SYNCW_RST = 14'h2AAA;
	localparam logic [3:0] AOCR_SYNCN_RST = 4'hA;
	localparam logic [2:0] AOCR_VREF_RST = 3'h0;
	localparam logic [2:0] AOCR_VREF_LAST_INT = 3'h4;
	localparam logic [15:0] AOCR_SOFT_RST_KEY = 16'hD2F0;
	localparam logic [13:0] AOCR_SYNC_CODE_OFF = 14'h0000;
	localparam logic [13:0] AOCR_SYNC_CODE_ONE = 14'h1555;
	localparam logic [13:0] AOCR_SYNC_CODE_PINS = 14'h2AAA;

	// ----------------------------------------------------------------
	// Timing and serial frame
	// ----------------------------------------------------------------
	localparam int AOCR_OVR_DELAY = 12;
	localparam logic [4:0] AOCR_HDR_LAST = 5'h08;
	localparam logic [4:0] AOCR_DATA_FIRST = 5'h0A;
	localparam logic [4:0] AOCR_FRAME_LAST = 5'h18;
	localparam logic [4:0] AOCR_FRAME_END = 5'h19;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		AOCR_SYNC_OFF = 2'b00,
		AOCR_SYNC_ONE_SHOT = 2'b01,
		AOCR_SYNC_PINS = 2'b10,
		AOCR_SYNC_UNSUP = 2'b11
	} aocr_sync_mode_t;

	typedef enum logic [1:0] {
		AOCR_SP_IDLE = 2'b00,
		AOCR_SP_SHIFT = 2'b01,
		AOCR_SP_DONE = 2'b10
	} aocr_sp_state_t;

endpackage

// >>> rtl/aocr_regs.sv
// Configuration bank: over-range threshold, offset loops, sync and reference.
// Assumes the host uses the serial port and samples arrive on core_clk_i.
`timescale 1ns/1ps

// How it works
// - over-range flag exactly twelve cycles late
// - level is 1.0 V times code/16
// - threshold resets to fifteen
// - one threshold feeds both channels
// - channel A loop runs at 0, cleared at 1
// - channel B loop runs at 0, cleared at 1
// - wide sync field decoded off/one-shot/pins/unsupported
// - narrow sync field decoded same four ways
// - reference code picks voltage or external
// - key write restores all defaults, self-clears
module aocr_regs #(
	parameter int SAMPLE_W = 12
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Serial register port
	input wire logic sen_n_i,
	input wire logic sclk_i,
	input wire logic sdata_i,
	output logic sdout_o,
	// Converter samples
	input wire logic [SAMPLE_W-1:0] sample_a_i,
	input wire logic [SAMPLE_W-1:0] sample_b_i,
	// Over-range flags
	output logic overrange_flag_a_o,
	output logic overrange_flag_b_o,
	// Offset loop controls
	output logic offset_loop_ctrl_a_o,
	output logic offset_loop_ctrl_b_o,
	// Clock generator sync
	output aocr_pkg::aocr_sync_mode_t sync_mode_o,
	output logic sync_mismatch_o,
	// Reference selection
	output logic [aocr_pkg::AOCR_VREF_W-1:0] vref_sel_o,
	output logic vref_external_o
);
	import aocr_pkg::*;

	logic wr_stb;
	logic [7:0] addr;
	logic [15:0] wr_data, rd_data;
	logic [AOCR_THR_W-1:0] thr_d, thr_q;
	logic [15:0] loop_a_d, loop_a_q, loop_b_d, loop_b_q;
	logic [AOCR_SYNCW_W-1:0] syncw_d, syncw_q;
	logic [AOCR_SYNCN_W-1:0] syncn_d, syncn_q;
	logic [AOCR_VREF_W-1:0] vref_d, vref_q;
	aocr_sync_mode_t mode_w, mode_n, mode_d;
	logic mismatch_d, vref_ext_d;

	// ----------------------------------------------------------------
	// Sync code decoding
	// ----------------------------------------------------------------
	function automatic aocr_sync_mode_t aocr_decode_sync(
			input logic [AOCR_SYNCW_W-1:0] code);
		case (code)
		AOCR_SYNC_CODE_OFF: aocr_decode_sync = AOCR_SYNC_OFF;
		AOCR_SYNC_CODE_ONE: aocr_decode_sync = AOCR_SYNC_ONE_SHOT;
		AOCR_SYNC_CODE_PINS: aocr_decode_sync = AOCR_SYNC_PINS;
		default: aocr_decode_sync = AOCR_SYNC_UNSUP;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Serial port and detectors
	// ----------------------------------------------------------------
	aocr_serial_port u_port (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.sen_n_i(sen_n_i),
		.sclk_i(sclk_i),
		.sdata_i(sdata_i),
		.sdout_o(sdout_o),
		.rd_data_i(rd_data),
		.wr_stb_o(wr_stb),
		.rd_stb_o(),
		.addr_o(addr),
		.wr_data_o(wr_data)
	);

	aocr_overrange_det #(
		.SAMPLE_W(SAMPLE_W),
		.DELAY(AOCR_OVR_DELAY)
	) u_ovr_a (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.sample_i(sample_a_i),
		.thr_i(thr_q),
		.overrange_flag_o(overrange_flag_a_o)
	);

	aocr_overrange_det #(
		.SAMPLE_W(SAMPLE_W),
		.DELAY(AOCR_OVR_DELAY)
	) u_ovr_b (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.sample_i(sample_b_i),
		.thr_i(thr_q),
		.overrange_flag_o(overrange_flag_b_o)
	);

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_comb begin
		thr_d = thr_q;
		loop_a_d = loop_a_q;
		loop_b_d = loop_b_q;
		syncw_d = syncw_q;
		syncn_d = syncn_q;
		vref_d = vref_q;
		if (wr_stb) begin
			case (addr)
			AOCR_OFS_OVR_THR: begin
				thr_d = wr_data[AOCR_THR_LSB +: AOCR_THR_W];
			end
			// performance bits stored as the host writes them
			AOCR_OFS_LOOP_A: begin
				loop_a_d = wr_data;
			end
			AOCR_OFS_LOOP_B: begin
				loop_b_d = wr_data;
			end
			AOCR_OFS_SYNC_WIDE: begin
				syncw_d = wr_data[AOCR_SYNCW_LSB +: AOCR_SYNCW_W];
			end
			AOCR_OFS_SYNC_REF: begin
				syncn_d = wr_data[AOCR_SYNCN_LSB +: AOCR_SYNCN_W];
				vref_d = wr_data[AOCR_VREF_LSB +: AOCR_VREF_W];
			end
			AOCR_OFS_SOFT_RST: begin
				if (wr_data == AOCR_SOFT_RST_KEY) begin
					thr_d = AOCR_THR_RST;
					loop_a_d = AOCR_LOOP_RST;
					loop_b_d = AOCR_LOOP_RST;
					syncw_d = AOCR_SYNCW_RST;
					syncn_d = AOCR_SYNCN_RST;
					vref_d = AOCR_VREF_RST;
				end
			end
			default: begin
				// Unmapped writes are dropped.
				thr_d = thr_q;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Decoded controls
	// ----------------------------------------------------------------
	always_comb begin
		mode_w = aocr_decode_sync(syncw_q);
		// narrow field decode, same patterns repeated
		mode_n = aocr_decode_sync({syncn_q, syncn_q, syncn_q, syncn_q[3:2]});
		// Disagreeing fields would leave the clock generator ambiguous,
		// so sync is held off until the host makes them agree.
		mismatch_d = (mode_w != mode_n);
		mode_d = mismatch_d ? AOCR_SYNC_OFF : mode_w;
		// codes beyond the last internal level are external
		vref_ext_d = (vref_q > AOCR_VREF_LAST_INT);
	end

	// ----------------------------------------------------------------
	// Read-back
	// ----------------------------------------------------------------
	// The reset key register always reads zero, as it self-clears.
	always_comb begin
		rd_data = '0;
		case (addr)
		AOCR_OFS_OVR_THR: begin
			rd_data[AOCR_THR_FIXED_BIT] = 1'b1;
			rd_data[AOCR_THR_LSB +: AOCR_THR_W] = thr_q;
		end
		AOCR_OFS_LOOP_A: begin
			rd_data = loop_a_q;
		end
		AOCR_OFS_LOOP_B: begin
			rd_data = loop_b_q;
		end
		AOCR_OFS_SYNC_WIDE: begin
			rd_data[AOCR_SYNCW_LSB +: AOCR_SYNCW_W] = syncw_q;
		end
		AOCR_OFS_SYNC_REF: begin
			rd_data[AOCR_SYNCN_LSB +: AOCR_SYNCN_W] = syncn_q;
			rd_data[AOCR_VREF_LSB +: AOCR_VREF_W] = vref_q;
		end
		default: begin
			rd_data = '0;
		end
		endcase
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			thr_q <= AOCR_THR_RST;
			loop_a_q <= AOCR_LOOP_RST;
			loop_b_q <= AOCR_LOOP_RST;
			syncw_q <= AOCR_SYNCW_RST;
			syncn_q <= AOCR_SYNCN_RST;
			vref_q <= AOCR_VREF_RST;
			offset_loop_ctrl_a_o <= 1'b1;
			offset_loop_ctrl_b_o <= 1'b1;
			sync_mode_o <= AOCR_SYNC_PINS;
			sync_mismatch_o <= 1'b0;
			vref_sel_o <= AOCR_VREF_RST;
			vref_external_o <= 1'b0;
		end else begin
			thr_q <= thr_d;
			loop_a_q <= loop_a_d;
			loop_b_q <= loop_b_d;
			syncw_q <= syncw_d;
			syncn_q <= syncn_d;
			vref_q <= vref_d;
			offset_loop_ctrl_a_o <= loop_a_q[AOCR_LOOP_BIT];
			offset_loop_ctrl_b_o <= loop_b_q[AOCR_LOOP_BIT];
			sync_mode_o <= mode_d;
			sync_mismatch_o <= mismatch_d;
			vref_sel_o <= vref_q;
			vref_external_o <= vref_ext_d;
		end
	end

endmodule

// >>> rtl/aocr_serial_port.sv
// Serial register port: synchronises the pins, frames commands, shifts reads.
// Assumes the serial clock is far slower than the core clock.
`timescale 1ns/1ps
module aocr_serial_port (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Serial pins
	input wire logic sen_n_i,
	input wire logic sclk_i,
	input wire logic sdata_i,
	output logic sdout_o,
	// Register side
	input wire logic [15:0] rd_data_i,
	output logic wr_stb_o,
	output logic rd_stb_o,
	output logic [7:0] addr_o,
	output logic [15:0] wr_data_o
);
	import aocr_pkg::*;

	logic [2:0] s1_q, s2_q, s3_q, f_q, f_d, prev_q;
	logic rise, fall;
	aocr_sp_state_t state_d, state_q;
	logic [4:0] cnt_d, cnt_q;
	logic [15:0] shreg_d, shreg_q, out_d, out_q;
	logic rd_d, rd_q, wr_stb_d, rd_stb_d, sdout_d;
	logic [7:0] addr_d;
	logic [15:0] wr_data_d;

	// ----------------------------------------------------------------
	// Pin filter
	// ----------------------------------------------------------------
	// A pin change is believed only once two late stages agree.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
		end
		rise = f_q[1] & ~prev_q[1];
		fall = ~f_q[1] & prev_q[1];
	end

	// ----------------------------------------------------------------
	// Frame engine
	// ----------------------------------------------------------------
	// Frame: read flag, address bits 7..0, then data bits 15..0.
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		shreg_d = shreg_q;
		out_d = out_q;
		rd_d = rd_q;
		addr_d = addr_o;
		wr_data_d = wr_data_o;
		sdout_d = sdout_o;
		wr_stb_d = 1'b0;
		rd_stb_d = 1'b0;
		if (f_q[0]) begin
			state_d = AOCR_SP_IDLE;
			cnt_d = '0;
			rd_d = 1'b0;
			sdout_d = 1'b0;
		end else begin
			case (state_q)
			AOCR_SP_IDLE: begin
				state_d = AOCR_SP_SHIFT;
				cnt_d = '0;
			end
			AOCR_SP_SHIFT: begin
				if (rise) begin
					shreg_d = {shreg_q[14:0], f_q[2]};
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == AOCR_HDR_LAST) begin
						addr_d = {shreg_q[6:0], f_q[2]};
						rd_d = shreg_q[7];
						rd_stb_d = shreg_q[7];
					end
					if (cnt_q == AOCR_FRAME_LAST) begin
						state_d = AOCR_SP_DONE;
						wr_data_d = {shreg_q[14:0], f_q[2]};
						wr_stb_d = ~rd_q;
					end
				end
				if (rd_stb_o) begin
					out_d = rd_data_i;
					sdout_d = rd_data_i[15];
				end else if (fall && rd_q && cnt_q >= AOCR_DATA_FIRST
						&& cnt_q < AOCR_FRAME_END) begin
					out_d = {out_q[14:0], 1'b0};
					sdout_d = out_q[14];
				end
			end
			AOCR_SP_DONE: begin
				// Extra clocks past a full frame are ignored.
				sdout_d = 1'b0;
			end
			default: begin
				state_d = AOCR_SP_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s1_q <= 3'h1;
			s2_q <= 3'h1;
			s3_q <= 3'h1;
			f_q <= 3'h1;
			prev_q <= 3'h1;
			state_q <= AOCR_SP_IDLE;
			cnt_q <= '0;
			shreg_q <= '0;
			out_q <= '0;
			rd_q <= 1'b0;
			addr_o <= '0;
			wr_data_o <= '0;
			sdout_o <= 1'b0;
			wr_stb_o <= 1'b0;
			rd_stb_o <= 1'b0;
		end else begin
			s1_q <= {sdata_i, sclk_i, sen_n_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= f_d;
			prev_q <= f_q;
			state_q <= state_d;
			cnt_q <= cnt_d;
			shreg_q <= shreg_d;
			out_q <= out_d;
			rd_q <= rd_d;
			addr_o <= addr_d;
			wr_data_o <= wr_data_d;
			sdout_o <= sdout_d;
			wr_stb_o <= wr_stb_d;
			rd_stb_o <= rd_stb_d;
		end
	end

endmodule

// >>> test/aocr_host_model.sv
// Host model that drives the serial register port of the bank.
// Assumes one core clock; pins change only at its falling edge.
`timescale 1ns/1ps
module aocr_host_model (
	// Clock
	input wire logic core_clk_i,
	// Serial pins
	output logic sen_n_o,
	output logic sclk_o,
	output logic sdata_o,
	input wire logic sdout_i
);
	// Half period of the serial clock, above the five-cycle minimum.
	localparam int HALF = 8;

	initial begin
		sen_n_o = 1'b1;
		sclk_o = 1'b0;
		sdata_o = 1'b0;
	end

	task automatic xfer(input logic rd, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] q);
		logic [24:0] f;
		f = {rd, a, d};
		q = 16'h0000;
		@(negedge core_clk_i);
		sen_n_o = 1'b0;
		for (int i = 24; i >= 0; i--) begin
			sdata_o = f[i];
			repeat (HALF) @(negedge core_clk_i);
			if (i < 16) begin
				q = {q[14:0], sdout_i};
			end
			sclk_o = 1'b1;
			repeat (HALF) @(negedge core_clk_i);
			sclk_o = 1'b0;
		end
		repeat (12) @(negedge core_clk_i);
		sen_n_o = 1'b1;
		// A released line must not keep looking like the last bit.
		sdata_o = ~sdata_o;
		repeat (HALF) @(negedge core_clk_i);
	endtask
endmodule

// >>> test/aocr_regs_chk.sv
// Checker for the bank's port relations.
// Assumes it is bound to the top of the bank.
`timescale 1ns/1ps
module aocr_regs_chk
	import aocr_pkg::*;
#(
	parameter int SAMPLE_W = 12
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Inputs watched
	input wire logic sen_n_i,
	input wire logic [SAMPLE_W-1:0] sample_a_i,
	input wire logic [SAMPLE_W-1:0] sample_b_i,
	// Outputs watched
	input wire logic overrange_flag_a_o,
	input wire logic overrange_flag_b_o,
	input wire logic offset_loop_ctrl_a_o,
	input wire logic offset_loop_ctrl_b_o,
	input wire aocr_pkg::aocr_sync_mode_t sync_mode_o,
	input wire logic sync_mismatch_o,
	input wire logic [2:0] vref_sel_o,
	input wire logic vref_external_o
);
	// Full scale exceeds every threshold, so it must always flag.
	localparam logic [SAMPLE_W-1:0] FS = {1'b1, {(SAMPLE_W-1){1'b0}}};
	logic [4:0] idle_q;
	logic [4:0] idle_d;

	always_comb begin
		idle_d = idle_q;
		if (!sen_n_i) begin
			idle_d = 5'h00;
		end else if (idle_q != 5'h1F) begin
			idle_d = idle_q + 5'h01;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			idle_q <= 5'h00;
		end else begin
			idle_q <= idle_d;
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	property p_ovr_full_a;
		$past(sample_a_i, 12) == FS |-> overrange_flag_a_o;
	endproperty
	a_ovr_full_a: assert property (p_ovr_full_a)
		else $error("flag a missing twelve cycles after full scale");
	property p_ovr_full_b;
		$past(sample_b_i, 12) == FS |-> overrange_flag_b_o;
	endproperty
	a_ovr_full_b: assert property (p_ovr_full_b)
		else $error("flag b missing twelve cycles after full scale");
	property p_ovr_pair;
		$past(sample_a_i, 12) == $past(sample_b_i, 12)
			|-> overrange_flag_a_o == overrange_flag_b_o;
	endproperty
	a_ovr_pair: assert property (p_ovr_pair)
		else $error("equal samples gave different flags");
	property p_rst_dflt;
		$fell(reset_i) |-> offset_loop_ctrl_a_o && offset_loop_ctrl_b_o
			&& sync_mode_o == AOCR_SYNC_PINS && vref_sel_o == 3'h0;
	endproperty
	a_rst_dflt: assert property (p_rst_dflt)
		else $error("outputs not at defaults after reset");
	property p_vref_ext;
		vref_external_o == (vref_sel_o > 3'h4);
	endproperty
	a_vref_ext: assert property (p_vref_ext)
		else $error("external reference flag disagrees with code");
	property p_sync_mis;
		sync_mismatch_o |-> sync_mode_o == AOCR_SYNC_OFF;
	endproperty
	a_sync_mis: assert property (p_sync_mis)
		else $error("mismatched sync fields left sync enabled");
	property p_loop_quiet;
		idle_q >= 5'h10 |-> $stable(offset_loop_ctrl_a_o)
			&& $stable(offset_loop_ctrl_b_o);
	endproperty
	a_loop_quiet: assert property (p_loop_quiet)
		else $error("loop control changed without a write");
	property p_sync_quiet;
		idle_q >= 5'h10 |-> $stable(sync_mode_o) && $stable(vref_sel_o);
	endproperty
	a_sync_quiet: assert property (p_sync_quiet)
		else $error("sync or reference changed without a write");

	c_flag: cover property (overrange_flag_a_o && !overrange_flag_b_o);
	c_mis: cover property (sync_mismatch_o);
	c_loop: cover property ($fell(offset_loop_ctrl_b_o));
endmodule

bind aocr_regs aocr_regs_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.core_clk_i,
	.reset_i, .sen_n_i, .sample_a_i, .sample_b_i, .overrange_flag_a_o,
	.overrange_flag_b_o, .offset_loop_ctrl_a_o, .offset_loop_ctrl_b_o,
	.sync_mode_o, .sync_mismatch_o, .vref_sel_o, .vref_external_o);

// >>> test/tb_adc_overrange_sync_cfg_regs.sv
// Bench for the bank: serial accesses, samples and output checks.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ps
module tb_adc_overrange_sync_cfg_regs;
	import aocr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sen_n, sclk, sdata, sdout, fa, fb, la, lb, mis, vext;
	logic [11:0] sa = 12'h000;
	logic [11:0] sb = 12'h000;
	logic [2:0] vsel;
	aocr_sync_mode_t mode;
	logic [15:0] outs;
	int num_errors = 0;
	int samples_checked = 0;
	logic [7:0] ra[7] = '{8'h02, 8'h03, 8'h1A, 8'h0E, 8'h0F, 8'h10, 8'h2C};
	logic [15:0] rv[7] = '{16'h4780, 16'h4B18, 16'h4B18, 16'hAAA8,
		16'hA000, 16'h0000, 16'h0000};
	logic [13:0] sw[5] = '{14'h0000, 14'h1555, 14'h3FFF, 14'h1555, 14'h2AAA};
	logic [3:0] sn[5] = '{4'h0, 4'h5, 4'hF, 4'hA, 4'hA};
	logic [2:0] se[5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h2};

	assign outs = {7'h00, la, lb, mis, vext, vsel, mode};

	aocr_regs #(.SAMPLE_W(12)) dut (.core_clk_i(clk), .reset_i(rst),
		.sen_n_i(sen_n), .sclk_i(sclk), .sdata_i(sdata), .sdout_o(sdout),
		.sample_a_i(sa), .sample_b_i(sb), .overrange_flag_a_o(fa),
		.overrange_flag_b_o(fb), .offset_loop_ctrl_a_o(la),
		.offset_loop_ctrl_b_o(lb), .sync_mode_o(mode),
		.sync_mismatch_o(mis), .vref_sel_o(vsel), .vref_external_o(vext));
	aocr_host_model host (.core_clk_i(clk), .sen_n_o(sen_n), .sclk_o(sclk),
		.sdata_o(sdata), .sdout_i(sdout));

	initial begin
		forever #2 clk = ~clk;
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] s, e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		host.xfer(1'b0, a, d, q);
	endtask

	task automatic rd_dflt();
		logic [15:0] q;
		for (int i = 0; i < 7; i++) begin
			host.xfer(1'b1, ra[i], 16'h0000, q);
			chk("dflt_read", q, rv[i]);
		end
	endtask

	// The flag is due on the eleventh edge after the sampling edge.
	task automatic overrange_flag(input logic [11:0] va, vb, input logic ea, eb);
		@(negedge clk);
		sa = va;
		sb = vb;
		@(negedge clk);
		sa = 12'h000;
		sb = 12'h000;
		repeat (11) @(negedge clk);
		chk("flags", {14'h0, fa, fb}, {14'h0, ea, eb});
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		stop_test();
	end

	initial begin
		logic [15:0] q;
		logic [11:0] lv;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk("outs", outs, {7'h00, 4'b1100, 3'h0, 2'b10});
		rd_dflt();
		wr(8'h02, 16'hFFFF);
		host.xfer(1'b1, 8'h02, 16'h0000, q);
		chk("thr_mixed", q, 16'h4780);
		for (int t = 1; t < 16; t += 7) begin
			lv = 12'(t << 7);
			wr(8'h02, {4'h0, lv});
			host.xfer(1'b1, 8'h02, 16'h0000, q);
			chk("thr_read", q, 16'h4000 | {4'h0, lv});
			overrange_flag(lv, lv - 12'h001, 1'b1, 1'b0);
			overrange_flag(lv - 12'h001, -lv, 1'b0, 1'b1);
		end
		overrange_flag(12'h800, 12'h800, 1'b1, 1'b1);
		wr(8'h03, 16'h0B18);
		chk("loop_a", outs, {7'h00, 4'b0100, 3'h0, 2'b10});
		wr(8'h1A, 16'h0B18);
		chk("loop_b", outs, {7'h00, 4'b0000, 3'h0, 2'b10});
		for (int i = 0; i < 5; i++) begin
			wr(8'h0E, {sw[i], 2'b00});
			wr(8'h0F, {sn[i], 12'h000});
			chk("sync", {13'h0, mis, mode}, {13'h0, se[i]});
		end
		for (int v = 0; v < 8; v++) begin
			wr(8'h0F, {4'hA, 5'h00, 3'(v), 4'h0});
			chk("vref", {12'h0, vext, vsel}, {12'h0, v > 4, 3'(v)});
		end
		// Move every field off its default so the key has work to do.
		wr(8'h02, 16'h0080);
		wr(8'h0E, 16'h0000);
		wr(8'h0F, 16'h5070);
		wr(8'h2C, 16'hD2F1);
		chk("no_key", outs, {7'h00, 4'b0011, 3'h7, 2'b00});
		wr(8'h2C, AOCR_SOFT_RST_KEY);
		chk("key", outs, {7'h00, 4'b1100, 3'h0, 2'b10});
		wr(8'h10, 16'hFFFF);
		rd_dflt();
		wr(8'h02, 16'h0080);
		wr(8'h03, 16'h0B18);
		@(negedge clk);
		rst = 1'b1;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk("outs_rst", outs, {7'h00, 4'b1100, 3'h0, 2'b10});
		host.xfer(1'b1, 8'h02, 16'h0000, q);
		chk("thr_rst", q, 16'h4780);
		stop_test();
	end
endmodule
